// ===== rtl/attr_pkg.sv
// constants shared by the attribute palette stage and its palette memory
// assumes one 200 MHz clock, pixel rate given as a one-cycle enable
package attr_pkg;

	// clock period, for reference by the surrounding timing logic
	localparam int CLK_PERIOD_NS = 5;

	// data register indexes, selected through the index register
	localparam logic [4:0] IDX_PAL_LAST = 5'h0f;
	localparam logic [4:0] IDX_MODE     = 5'h10;
	localparam logic [4:0] IDX_BORDER   = 5'h11;
	localparam logic [4:0] IDX_PLANE    = 5'h12;
	localparam logic [4:0] IDX_SHIFT    = 5'h13;
	localparam logic [4:0] IDX_CSEL     = 5'h14;

	// index register fields
	localparam int IDXF_PAL_SRC = 5;
	localparam int IDXF_WIDTH   = 6;

	// attr_mode_control field positions
	localparam int MODE_SRC_SEL    = 7;
	localparam int MODE_PIX_W      = 6;
	localparam int MODE_PAN_COMPAT = 5;
	localparam int MODE_BLINK      = 3;
	localparam int MODE_LGFX       = 2;
	localparam int MODE_MONO       = 1;
	localparam int MODE_GFX        = 0;

	// writable bits of attr_mode_control, bit 4 is reserved
	localparam logic [7:0] MODE_WMASK = 8'hef;

	// reset values
	localparam logic [5:0] RST_INDEX  = 6'h00;
	localparam logic [7:0] RST_MODE   = 8'h00;
	localparam logic [7:0] RST_BORDER = 8'h00;
	localparam logic [3:0] RST_PLANE  = 4'hf;
	localparam logic [3:0] RST_SHIFT  = 4'h0;
	localparam logic [3:0] RST_CSEL   = 4'h0;
	localparam logic [5:0] RST_PAL    = 6'h00;

	// line-graphics character code range
	localparam logic [7:0] LGFX_FIRST = 8'hc0;
	localparam logic [7:0] LGFX_LAST  = 8'hdf;

	// panning limits, delay line holds PAN_MAX+1 pixels
	localparam logic [3:0] PAN_MAX    = 4'h8;
	localparam logic [3:0] PAN_STD_LIM = 4'h7;

	// palette geometry
	localparam int PAL_ENTRIES = 16;
	localparam int PAL_W       = 6;

endpackage

// ===== rtl/palette_ram.sv
// sixteen-entry palette store with one write and two registered reads
// assumes writes and reads are qualified by single-cycle enables
`timescale 1ns/1ps
module palette_ram (
	input  wire logic                       clk,     // system clock
	input  wire logic                       rst_n,   // sync reset, low
	input  wire logic                       wr_en,   // write strobe
	input  wire logic [3:0]                 wr_addr, // write entry
	input  wire logic [attr_pkg::PAL_W-1:0] wr_data, // write value
	input  wire logic                       va_en,   // video read enable
	input  wire logic [3:0]                 va_addr, // video read entry
	output logic      [attr_pkg::PAL_W-1:0] va_q,    // video read data
	input  wire logic                       cb_en,   // cpu read enable
	input  wire logic [3:0]                 cb_addr, // cpu read entry
	output logic      [attr_pkg::PAL_W-1:0] cb_q     // cpu read data
);
	import attr_pkg::*;

	typedef struct packed {
		logic [PAL_ENTRIES-1:0][PAL_W-1:0] arr;
		logic [PAL_W-1:0]                  va;
		logic [PAL_W-1:0]                  cb;
	} ram_state_t;

	ram_state_t s_r;
	ram_state_t s_nxt;

	// read data leave from a register so the caller sees a fixed latency
	always_comb begin
		s_nxt = s_r;
		if (wr_en) begin
			s_nxt.arr[wr_addr] = wr_data;
		end
		if (va_en) begin
			s_nxt.va = s_r.arr[va_addr];
		end
		if (cb_en) begin
			s_nxt.cb = s_r.arr[cb_addr];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '{arr: {PAL_ENTRIES{RST_PAL}}, va: RST_PAL, cb: RST_PAL};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign va_q = s_r.va;
	assign cb_q = s_r.cb;
endmodule

// ===== rtl/attribute_palette_controller.sv
// attribute stage: indexed register pair, palette lookup, panning,
// blink, ninth dot, border and colour-select merge toward the dac
// assumes pixel data arrive one pixel per pix_en pulse, and that the
// crt controller drives line compare, vertical sync and border timing
`timescale 1ns/1ps
module attribute_palette_controller (
	input  wire logic       clk,             // 200 MHz system clock
	input  wire logic       rst_n,           // sync reset, low
	input  wire logic       io_wr,           // write strobe, shared port
	input  wire logic [7:0] io_wdata,        // write data
	input  wire logic       io_rd,           // read strobe, read port
	input  wire logic       status1_rd,      // status one was read
	output logic      [7:0] io_rdata,        // read data
	output logic            rd_valid,        // read data valid pulse
	input  wire logic       pix_en,          // one pulse per pixel
	input  wire logic [3:0] dot_planes,      // plane bits, graphics
	input  wire logic [7:0] pix_byte,        // full byte, byte mode
	input  wire logic [7:0] char_code,       // character code, text
	input  wire logic [7:0] char_attr,       // attribute byte, text
	input  wire logic       glyph_dot,       // font dot, text
	input  wire logic       dot_ninth,       // this is the ninth dot
	input  wire logic       nine_dot_mode,   // nine-dot text timing
	input  wire logic       border_active,   // pixel lies in border
	input  wire logic       line_cmp_match,  // line compare hit pulse
	input  wire logic       vsync,           // vertical sync
	input  wire logic       blink_phase,     // high hides blinking text
	output logic      [7:0] dac_pixel_index, // index toward the dac
	output logic            pan_forced       // panning held at zero
);
	import attr_pkg::*;

	typedef struct packed {
		logic                  ff;       // 0 index phase, 1 data phase
		logic [IDXF_WIDTH-1:0] index;
		logic [7:0]            mode;
		logic [7:0]            border;
		logic [3:0]            planes;
		logic [3:0]            shift;
		logic [3:0]            csel;
		logic                  hold;     // panning held at zero
		logic                  prev_dot; // eighth dot memory
		logic [8:0][7:0]       line;     // panning delay line
		logic [8:0]            brd;      // border flags, fixed delay
		logic [7:0]            tap;
		logic                  brd_q;
		logic [7:0]            dac;
		logic                  rd_pend;
		logic [4:0]            rd_idx;
		logic [7:0]            rdata;
		logic                  rd_vld;
	} ctl_state_t;

	ctl_state_t s_r;
	ctl_state_t s_nxt;

	logic [PAL_W-1:0] pal_va;
	logic [PAL_W-1:0] pal_cb;
	logic             pal_we;
	logic [3:0]       sh_eff;
	logic [3:0]       tap_sel;

	// effective pixel shift for the programmed value and mode
	function automatic logic [3:0] pan_count(input logic [3:0] raw,
	                                         input logic       byte_mode,
	                                         input logic       nine);
		logic [3:0] c;
		c = 4'h0;
		if (byte_mode) begin
			if (!raw[0] && raw <= PAN_STD_LIM) begin
				c = {2'b00, raw[2:1]};
			end
		end else if (nine) begin
			if (raw <= PAN_STD_LIM) begin
				c = raw + 4'h1;
			end
		end else if (raw <= PAN_STD_LIM) begin
			c = raw;
		end
		return c;
	endfunction

	// line-graphics codes get a ninth dot copied from the eighth
	function automatic logic in_lgfx(input logic [7:0] code);
		return (code >= LGFX_FIRST) && (code <= LGFX_LAST);
	endfunction

	// palette entries live in their own store; video reads per pixel
	assign pal_we = io_wr && s_r.ff && (s_r.index[4:0] <= IDX_PAL_LAST);

	palette_ram u_pal (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (pal_we),
		.wr_addr (s_r.index[3:0]),
		.wr_data (io_wdata[PAL_W-1:0]),
		.va_en   (pix_en),
		.va_addr (s_r.line[tap_sel][3:0]),
		.va_q    (pal_va),
		.cb_en   (io_rd),
		.cb_addr (s_r.index[3:0]),
		.cb_q    (pal_cb)
	);

	// zero shift while a line-compare hold is in force
	assign sh_eff = (s_r.hold && s_r.mode[MODE_PAN_COMPAT]) ? 4'h0 :
	                pan_count(s_r.shift, s_r.mode[MODE_PIX_W],
	                          nine_dot_mode);
	// newest pixel at 0; a larger shift taps a younger pixel
	assign tap_sel = PAN_MAX - sh_eff;

	always_comb begin
		logic [3:0] fg;
		logic [3:0] bg;
		logic [3:0] c4;
		logic [7:0] c8;
		logic       dot;
		logic       blink_on;
		fg = char_attr[3:0];
		bg = 4'h0;
		c4 = 4'h0;
		c8 = 8'h00;
		dot = 1'b0;
		blink_on = s_r.mode[MODE_BLINK];
		s_nxt = s_r;

		// index/data flip-flop; the status read wins over a write
		if (status1_rd) begin
			s_nxt.ff = 1'b0;
		end else if (io_wr) begin
			s_nxt.ff = ~s_r.ff;
		end

		// register writes; reserved bits are dropped here
		if (io_wr && !s_r.ff) begin
			s_nxt.index = io_wdata[IDXF_WIDTH-1:0];
		end else if (io_wr) begin
			if (s_r.index[4:0] == IDX_MODE) begin
				s_nxt.mode = io_wdata & MODE_WMASK;
			end else if (s_r.index[4:0] == IDX_BORDER) begin
				s_nxt.border = io_wdata;
			end else if (s_r.index[4:0] == IDX_PLANE) begin
				s_nxt.planes = io_wdata[3:0];
			end else if (s_r.index[4:0] == IDX_SHIFT) begin
				s_nxt.shift = io_wdata[3:0];
			end else if (s_r.index[4:0] == IDX_CSEL) begin
				s_nxt.csel = io_wdata[3:0];
			end
		end

		// reads take two cycles because the palette store is registered
		s_nxt.rd_pend = io_rd;
		s_nxt.rd_vld = s_r.rd_pend;
		if (io_rd) begin
			s_nxt.rd_idx = s_r.index[4:0];
		end
		if (s_r.rd_pend) begin
			if (s_r.rd_idx <= IDX_PAL_LAST) begin
				s_nxt.rdata = {2'b00, pal_cb};
			end else if (s_r.rd_idx == IDX_MODE) begin
				s_nxt.rdata = s_r.mode;
			end else if (s_r.rd_idx == IDX_BORDER) begin
				s_nxt.rdata = s_r.border;
			end else if (s_r.rd_idx == IDX_PLANE) begin
				s_nxt.rdata = {4'h0, s_r.planes};
			end else if (s_r.rd_idx == IDX_SHIFT) begin
				s_nxt.rdata = {4'h0, s_r.shift};
			end else if (s_r.rd_idx == IDX_CSEL) begin
				s_nxt.rdata = {4'h0, s_r.csel};
			end else begin
				s_nxt.rdata = 8'h00;               // unmapped index
			end
		end

		// line compare sets the hold, vertical sync ends it; set wins
		if (s_r.mode[MODE_PAN_COMPAT] && line_cmp_match) begin
			s_nxt.hold = 1'b1;
		end else if (vsync) begin
			s_nxt.hold = 1'b0;
		end

		// ninth dot: copy of the eighth only for line-graphics codes
		if (dot_ninth) begin
			dot = s_r.mode[MODE_LGFX] && in_lgfx(char_code) &&
			      s_r.prev_dot;
		end else begin
			dot = glyph_dot;
		end
		// top attribute bit: blink enable or background intensity
		if (blink_on) begin
			bg = {1'b0, char_attr[6:4]};
			if (char_attr[7] && blink_phase) begin
				dot = 1'b0;
			end
		end else begin
			bg = char_attr[7:4];
		end
		if (s_r.mode[MODE_GFX]) begin
			c4 = dot_planes;
		end else begin
			c4 = dot ? fg : bg;
		end
		// monochrome: on/off from bit 0, intensity from bit 3
		if (s_r.mode[MODE_MONO]) begin
			c4 = {c4[3], {3{c4[0]}}};
		end
		if (s_r.mode[MODE_PIX_W]) begin
			c8 = pix_byte;
		end else begin
			c8 = {4'h0, c4 & s_r.planes};
		end

		// pixel pipeline: delay line, tap, then dac index merge
		if (pix_en) begin
			if (!dot_ninth) begin
				s_nxt.prev_dot = glyph_dot;
			end
			s_nxt.line = {s_r.line[7:0], c8};
			s_nxt.brd = {s_r.brd[7:0], border_active};
			s_nxt.tap = s_r.line[tap_sel];
			s_nxt.brd_q = s_r.brd[PAN_MAX];
			if (s_r.brd_q || !s_r.index[IDXF_PAL_SRC]) begin
				s_nxt.dac = s_r.border;
			end else if (s_r.mode[MODE_PIX_W]) begin
				s_nxt.dac = s_r.tap;
			end else if (s_r.mode[MODE_SRC_SEL]) begin
				s_nxt.dac = {s_r.csel, pal_va[3:0]};
			end else begin
				s_nxt.dac = {s_r.csel[3:2], pal_va};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '{ff: 1'b0, index: RST_INDEX, mode: RST_MODE,
			         border: RST_BORDER, planes: RST_PLANE,
			         shift: RST_SHIFT, csel: RST_CSEL, hold: 1'b0,
			         prev_dot: 1'b0, line: '0, brd: '0, tap: 8'h00,
			         brd_q: 1'b0, dac: 8'h00, rd_pend: 1'b0,
			         rd_idx: 5'h00, rdata: 8'h00, rd_vld: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign io_rdata        = s_r.rdata;
	assign rd_valid        = s_r.rd_vld;
	assign dac_pixel_index = s_r.dac;
	assign pan_forced      = s_r.hold;

	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// an index write followed by a data write to the plane register
	sequence wr_index_s;
		io_wr && !status1_rd && !s_r.ff;
	endsequence
	sequence wr_plane_s;
		io_wr && !status1_rd && s_r.ff && s_r.index[4:0] == IDX_PLANE;
	endsequence

	// register port: flip-flop phase and its clearing
	ff_toggles_a: assert property (io_wr && !status1_rd |=>
		s_r.ff != $past(s_r.ff))
		else $error("flip-flop did not toggle on write");
	ff_read_keep_a: assert property (io_rd && !status1_rd &&
		!io_wr |=> $stable(s_r.ff))
		else $error("read port changed the flip-flop");
	status_clear_a: assert property (status1_rd |=> !s_r.ff and
		(io_wr && !status1_rd |=> s_r.ff))
		else $error("status read did not restart index phase");
	plane_write_a: assert property (wr_index_s ##[1:2] wr_plane_s |=>
		s_r.planes == $past(io_wdata[3:0]) && s_r.ff == 1'b0)
		else $error("index then data write not applied");
	pan_hold_set_a: assert property (s_r.mode[MODE_PAN_COMPAT] &&
		line_cmp_match |=> s_r.hold && sh_eff == 4'h0)
		else $error("line compare did not hold panning at zero");
	pan_hold_end_a: assert property (vsync && !line_cmp_match |=>
		!s_r.hold)
		else $error("vertical sync did not end panning hold");
	reserved_zero_a: assert property (s_r.rd_vld &&
		s_r.rd_idx >= IDX_PLANE && s_r.rd_idx <= IDX_CSEL |->
		io_rdata[7:4] == 4'h0)
		else $error("reserved bits read as nonzero");
	// output merge, one pixel after the tap
	border_out_a: assert property (pix_en && s_r.brd_q |=>
		dac_pixel_index == $past(s_r.border))
		else $error("border colour not driven in border");
	byte_pass_a: assert property (pix_en && !s_r.brd_q &&
		s_r.index[IDXF_PAL_SRC] && s_r.mode[MODE_PIX_W] |=>
		dac_pixel_index == $past(s_r.tap))
		else $error("byte mode index not passed through");
	bank_bits_a: assert property (pix_en && !s_r.brd_q &&
		s_r.index[IDXF_PAL_SRC] && !s_r.mode[MODE_PIX_W] |=>
		dac_pixel_index[7:6] == $past(s_r.csel[3:2]))
		else $error("colour bank bits wrong");
	src_sel_a: assert property (pix_en && !s_r.brd_q &&
		s_r.index[IDXF_PAL_SRC] && !s_r.mode[MODE_PIX_W] |=>
		dac_pixel_index[5:4] == ($past(s_r.mode[MODE_SRC_SEL]) ?
		$past(s_r.csel[1:0]) : $past(pal_va[5:4])))
		else $error("bits five and four from wrong source");
	nine_pan_a: assert property (nine_dot_mode &&
		!s_r.mode[MODE_PIX_W] && !s_r.hold && s_r.shift == PAN_MAX |->
		tap_sel == PAN_MAX)
		else $error("nine-dot value 8 did not give zero shift");

	// index capture, palette source, reserved bits, read latency
	index_load_a: assert property (wr_index_s |=>
		s_r.index == $past(io_wdata[IDXF_WIDTH-1:0]))
		else $error("index write not captured");
	pal_src_a: assert property (pix_en &&
		!s_r.index[IDXF_PAL_SRC] |=> dac_pixel_index == $past(s_r.border))
		else $error("palette source low did not show border");
	mode_rsvd_a: assert property (io_wr && s_r.ff &&
		s_r.index[4:0] == IDX_MODE |=> (s_r.mode & ~MODE_WMASK) == 8'h00)
		else $error("reserved mode bit was written");
	compat_off_a: assert property (!s_r.mode[MODE_PAN_COMPAT] &&
		!s_r.hold |=> !s_r.hold)
		else $error("line compare held panning with compat clear");
	rd_answer_a: assert property (io_rd |-> ##2 rd_valid)
		else $error("read data valid not two cycles after strobe");
endmodule

// ===== testbench/dac_sink.sv
// dac side model: takes the pixel index once per pixel, as the dac does
// assumes dac_pixel_index is settled at every pix_en edge
`timescale 1ns/1ps
module dac_sink (
	input  wire logic       clk,     // system clock
	input  wire logic       pix_en,  // pixel strobe
	input  wire logic [7:0] pix_idx, // index from the block
	output logic      [7:0] last_idx // last index looked up
);
	// one pixel late on purpose, the lookup sits behind a register
	always_ff @(posedge clk) begin
		if (pix_en) begin
			last_idx <= pix_idx;
		end
	end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the attribute palette stage
// assumes the design under rtl/ and the dac model in dac_sink.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	import attr_pkg::*;
	logic       clk, rst_n, io_wr, io_rd, status1_rd, rd_valid, pix_en;
	logic       glyph_dot, dot_ninth, nine_dot_mode, border_active;
	logic       line_cmp_match, vsync, blink_phase, pan_forced, psrc;
	logic [7:0] io_wdata, io_rdata, pix_byte, char_code, char_attr;
	logic [7:0] dac_pixel_index, last_idx;
	logic [3:0] dot_planes;
	int         error_cnt = 0;
	int         tests_run = 0;
	attribute_palette_controller u_dut (.clk(clk), .rst_n(rst_n),
		.io_wr(io_wr), .io_wdata(io_wdata), .io_rd(io_rd),
		.status1_rd(status1_rd), .io_rdata(io_rdata), .rd_valid(rd_valid),
		.pix_en(pix_en), .dot_planes(dot_planes), .pix_byte(pix_byte),
		.char_code(char_code), .char_attr(char_attr), .glyph_dot(glyph_dot),
		.dot_ninth(dot_ninth), .nine_dot_mode(nine_dot_mode),
		.border_active(border_active), .line_cmp_match(line_cmp_match),
		.vsync(vsync), .blink_phase(blink_phase),
		.dac_pixel_index(dac_pixel_index), .pan_forced(pan_forced));
	dac_sink u_sink (.clk(clk), .pix_en(pix_en), .pix_idx(dac_pixel_index),
		.last_idx(last_idx));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// palette contents chosen so every entry differs
	function automatic logic [5:0] palv(input logic [3:0] i);
		return 6'(i * 5 + 3);
	endfunction
	// colour select is held at 9, so its top pair is 2'b10
	function automatic logic [7:0] gx(input logic [3:0] c);
		return {2'b10, palv(c)};
	endfunction
	// effective shift: 0 byte mode, 1 nine-dot text, 2 others
	function automatic int es(input int m, input int v);
		if (m == 0) return (v % 2 == 0 && v < 8) ? v / 2 : 0;
		if (m == 1) return (v < 8) ? v + 1 : 0;
		return (v < 8) ? v : 0;
	endfunction
	task automatic wr(input logic [7:0] b);
		@(posedge clk);
		io_wr    <= 1'b1;
		io_wdata <= b;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask
	task automatic pulse_s1();
		@(posedge clk);
		status1_rd <= 1'b1;
		@(posedge clk);
		status1_rd <= 1'b0;
	endtask
	// flip-flop to index phase, index, then data
	task automatic reg_wr(input logic [4:0] idx, input logic [7:0] v);
		pulse_s1();
		wr({2'b00, psrc, idx});
		wr(v);
	endtask
	// read answers two cycles after the strobe edge
	task automatic chk_rd(input logic [4:0] idx, input logic [7:0] e);
		pulse_s1();
		wr({2'b00, psrc, idx});
		@(posedge clk);
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(rd_valid, 1'b1)
		`CHK(io_rdata, e)
		@(posedge clk);
	endtask
	// hold the inputs and let the pipe fill, then look at the dac side
	task automatic vid(input logic [7:0] e);
		repeat (14) @(posedge clk);
		#1;
		`CHK(last_idx, e)
		@(posedge clk);
	endtask
	// a rising pixel stream, so the output tells how far it was shifted
	task automatic stream(input logic [7:0] e);
		for (int i = 0; i < 21; i++) begin
			@(posedge clk);
			pix_byte   <= 8'(i);
			dot_planes <= 4'(i);
		end
		#1;
		`CHK(dac_pixel_index, e)
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// watchdog, far beyond the fewer than two thousand cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		{io_wr, io_rd, status1_rd, line_cmp_match, vsync} = '0;
		{blink_phase, glyph_dot, dot_ninth, nine_dot_mode} = '0;
		border_active = 1'b0;
		{io_wdata, pix_byte, char_code, char_attr} = '0;
		dot_planes = 4'h0;
		pix_en = 1'b1;
		psrc = 1'b1;
		rst_n = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		// reset values; index 15 is unmapped
		chk_rd(5'h00, 8'h00);
		chk_rd(IDX_MODE, 8'h00);
		chk_rd(IDX_PLANE, 8'h0f);
		chk_rd(5'h15, 8'h00);
		// reserved bits are dropped
		reg_wr(IDX_MODE, 8'hff);
		chk_rd(IDX_MODE, MODE_WMASK);
		reg_wr(IDX_SHIFT, 8'hff);
		chk_rd(IDX_SHIFT, 8'h0f);
		reg_wr(IDX_CSEL, 8'hff);
		chk_rd(IDX_CSEL, 8'h0f);
		// a read leaves the flip-flop in data phase
		chk_rd(IDX_BORDER, 8'h00);
		wr(8'h5a);
		chk_rd(IDX_BORDER, 8'h5a);
		// status one read turns a would-be data write into an index
		pulse_s1();
		wr({2'b00, psrc, IDX_CSEL});
		wr(8'h09);
		chk_rd(IDX_CSEL, 8'h09);
		chk_rd(IDX_BORDER, 8'h5a);
		// palette loaded with source bit low, inside vertical retrace
		psrc = 1'b0;
		vsync <= 1'b1;
		reg_wr(5'h00, 8'hff);
		chk_rd(5'h00, 8'h3f);
		for (int i = 0; i < 16; i++) reg_wr(5'(i), {2'b11, palv(4'(i))});
		vsync <= 1'b0;
		psrc = 1'b1;
		chk_rd(5'h09, {2'b00, palv(4'h9)});
		// graphics path, planes masked to 5
		reg_wr(IDX_SHIFT, 8'h00);
		reg_wr(IDX_BORDER, 8'ha5);
		reg_wr(IDX_PLANE, 8'h05);
		reg_wr(IDX_MODE, 8'h01);
		dot_planes <= 4'hb;
		vid(gx(4'h1));
		reg_wr(IDX_MODE, 8'h81);
		vid({4'h9, 4'(palv(4'h1))});
		reg_wr(IDX_MODE, 8'h03);
		vid(gx(4'h5));
		// text path, attribute fg 2 bg c
		reg_wr(IDX_PLANE, 8'h0f);
		reg_wr(IDX_MODE, 8'h00);
		char_attr <= 8'hc2;
		glyph_dot <= 1'b1;
		vid(gx(4'h2));
		glyph_dot <= 1'b0;
		vid(gx(4'hc));
		reg_wr(IDX_MODE, 8'h08);
		vid(gx(4'h4));
		glyph_dot   <= 1'b1;
		blink_phase <= 1'b1;
		vid(gx(4'h4));
		blink_phase <= 1'b0;
		vid(gx(4'h2));
		// ninth dot at the ends of the line-graphics range
		reg_wr(IDX_MODE, 8'h04);
		dot_ninth <= 1'b1;
		char_code <= LGFX_FIRST;
		vid(gx(4'h2));
		char_code <= LGFX_LAST;
		vid(gx(4'h2));
		char_code <= 8'he0;
		vid(gx(4'hc));
		char_code <= 8'hbf;
		vid(gx(4'hc));
		reg_wr(IDX_MODE, 8'h00);
		char_code <= LGFX_FIRST;
		vid(gx(4'hc));
		// a dark eighth dot must leave the copied ninth dot dark
		reg_wr(IDX_MODE, 8'h04);
		dot_ninth <= 1'b0;
		glyph_dot <= 1'b0;
		@(posedge clk);
		dot_ninth <= 1'b1;
		glyph_dot <= 1'b1;
		vid(gx(4'hc));
		dot_ninth <= 1'b0;
		// border, then palette source low also shows border
		border_active <= 1'b1;
		vid(8'ha5);
		border_active <= 1'b0;
		pulse_s1();
		wr({3'b000, IDX_MODE});
		vid(8'ha5);
		// panning values 0 to 8 in every shift table
		for (int m = 0; m < 3; m++) begin
			nine_dot_mode <= (m == 1);
			reg_wr(IDX_MODE, (m == 0) ? 8'h40 : 8'h01);
			for (int v = 0; v < 9; v++) begin
				reg_wr(IDX_SHIFT, 8'(v));
				if (m == 0) begin
					stream(8'(9 + es(m, v)));
				end else begin
					stream(gx(4'(9 + es(m, v))));
				end
			end
		end
		nine_dot_mode <= 1'b0;
		// line compare hold, byte mode shift 4 gives 2
		reg_wr(IDX_MODE, 8'h60);
		reg_wr(IDX_SHIFT, 8'h04);
		@(posedge clk);
		line_cmp_match <= 1'b1;
		@(posedge clk);
		line_cmp_match <= 1'b0;
		#1;
		`CHK(pan_forced, 1'b1)
		stream(8'h09);
		@(posedge clk);
		vsync <= 1'b1;
		@(posedge clk);
		vsync <= 1'b0;
		#1;
		`CHK(pan_forced, 1'b0)
		stream(8'h0b);
		reg_wr(IDX_MODE, 8'h40);
		@(posedge clk);
		line_cmp_match <= 1'b1;
		@(posedge clk);
		line_cmp_match <= 1'b0;
		stream(8'h0b);
		`CHK(pan_forced, 1'b0)
		print_verdict();
	end
endmodule
